/* File: design/tcp_edge_sync.sv */
// Three-stage synchroniser with a settled-level rising edge detector.
// Assumes the input is asynchronous to clk_i; rise_o is a one-cycle pulse.
`timescale 1ns/1ps
module tcp_edge_sync
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic rise_o
);

	logic meta;
	logic stage_two;
	logic stage_three;
	logic settled;

	// Only the second stage reads the first, to keep metastability contained
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta <= 1'b0;
			stage_two <= 1'b0;
			stage_three <= 1'b0;
		end
		else
		begin
			meta <= async_i;
			stage_two <= meta;
			stage_three <= stage_two;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			settled <= 1'b0;
			rise_o <= 1'b0;
		end
		else
		begin
			if (stage_two == stage_three)
			begin
				settled <= stage_three;
			end
			rise_o <= (stage_two == stage_three) && stage_three && !settled;
		end
	end

endmodule : tcp_edge_sync

/* File: design/tcp_pkg.sv */
// Shared constants and carrier types for the timer run and capture control block.
// Assumes a single 125 MHz core clock and a synchronous active-high reset.
package tcp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_TIMER_ONE = 6'h10;
	localparam logic [5:0] IDX_TIMER_TWO = 6'h11;
	localparam logic [5:0] IDX_T3_LOW = 6'h12;
	localparam logic [5:0] IDX_T3_HIGH = 6'h13;
	localparam logic [5:0] IDX_CAP2_LOW = 6'h14;
	localparam logic [5:0] IDX_CAP2_HIGH = 6'h15;
	localparam logic [5:0] IDX_CLOCK_EDGE_CFG = 6'h16;
	localparam logic [5:0] IDX_RUN_CAPTURE_CTL = 6'h17;
	localparam logic [5:0] IDX_PERCAP_LOW = 6'h18;
	localparam logic [5:0] IDX_PERCAP_HIGH = 6'h19;
	localparam logic [5:0] IDX_PORT_B_DIR = 6'h1A;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h1B;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h1C;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CFG_CASCADE_BIT = 3;
	localparam int PB_PWM1_BIT = 2;
	localparam int PB_PWM2_BIT = 3;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam int EV_W = 5;
	localparam int EV_CAP1 = 0;
	localparam int EV_CAP2 = 1;
	localparam int EV_OVF1 = 2;
	localparam int EV_OVF2 = 3;
	localparam int EV_T3_WRAP = 4;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
	localparam logic [15:0] T3_MAX = 16'hFFFF;
	localparam logic [15:0] T3_START = 16'h0000;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cap2_ovf;
		logic cap1_ovf;
		logic second_pwm_enable;
		logic first_pwm_enable;
		logic capture_or_period_select;
		logic timer_three_run;
		logic timer_two_run;
		logic timer_one_run;
	} tcp_ctl_s;

	typedef struct packed {
		logic out;
		logic oe;
	} tcp_pin_s;

endpackage : tcp_pkg

/* File: design/tcp_timer_control.sv */
// Timer run control, capture registers, PWM pin steering and interrupts.
// Assumes an Avalon-MM master with byte addresses and one 125 MHz clock.
`timescale 1ns/1ps
module tcp_timer_control
#(
	parameter int ADDR_W = 8
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic capture_one_i,
	input wire logic capture_two_i,
	input wire logic first_pwm_level_i,
	input wire logic second_pwm_level_i,
	input wire logic first_port_latch_i,
	input wire logic second_port_latch_i,
	output tcp_pkg::tcp_pin_s first_pwm_pin_o,
	output tcp_pkg::tcp_pin_s second_pwm_pin_o,
	output logic irq_o
);
	import tcp_pkg::*;

	// Narrower addresses could not reach the register block, so refuse them at elaboration
	if (ADDR_W < 8)
	begin : g_bad_addr_w
		$error("ADDR_W must be at least 8");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tcp_ctl_s ctl;
	logic [7:0] cfg;
	logic [7:0] port_b_direction;
	logic [7:0] timer_one;
	logic [7:0] timer_two;
	logic [15:0] third_timer_count;
	logic [15:0] percap;
	logic [15:0] cap_two;
	logic unread_one;
	logic unread_two;
	logic [1:0] got_one;
	logic [1:0] got_two;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic cap_one_rise;
	logic cap_two_rise;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic req;
	logic accept;
	logic aligned;
	logic [5:0] idx;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] wbyte;

	assign req = avs_read || avs_write;
	// The access completes on the edge where waitrequest is already low
	assign accept = req && !avs_waitrequest;
	// A shift keeps the upper-bit test legal when ADDR_W is exactly 8
	assign aligned = (avs_address[1:0] == 2'b00) && ((avs_address >> 8) == '0);
	assign idx = avs_address[7:2];
	assign wr_hit = accept && avs_write && aligned && avs_byteenable[0];
	assign rd_hit = accept && avs_read && aligned;
	assign wbyte = avs_writedata[7:0];

	// One wait cycle per access, then release for the completing edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			avs_waitrequest <= !(req && avs_waitrequest);
		end
	end

	// ----------------------------------------------------------------
	// Capture inputs
	// ----------------------------------------------------------------
	tcp_edge_sync u_sync_one
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(capture_one_i),
		.rise_o(cap_one_rise)
	);

	tcp_edge_sync u_sync_two
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(capture_two_i),
		.rise_o(cap_two_rise)
	);

	logic cap1_mode;
	logic ev_cap1;
	logic ev_cap2;
	logic done_one;
	logic done_two;
	logic take_one;
	logic take_two;
	logic ovf_one;
	logic ovf_two;

	assign cap1_mode = ctl.capture_or_period_select;
	assign ev_cap1 = cap_one_rise && cap1_mode;
	assign ev_cap2 = cap_two_rise;
	// A read that finishes both bytes this cycle frees the register for a new capture
	assign done_one = (got_one[0] || (rd_hit && idx == IDX_PERCAP_LOW))
		&& (got_one[1] || (rd_hit && idx == IDX_PERCAP_HIGH));
	assign done_two = (got_two[0] || (rd_hit && idx == IDX_CAP2_LOW))
		&& (got_two[1] || (rd_hit && idx == IDX_CAP2_HIGH));
	assign take_one = ev_cap1 && (!unread_one || done_one);
	assign take_two = ev_cap2 && (!unread_two || done_two);
	assign ovf_one = ev_cap1 && !take_one;
	assign ovf_two = ev_cap2 && !take_two;

	// Capture-one bookkeeping; leaving capture mode forgets the unread state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			unread_one <= 1'b0;
			got_one <= 2'b00;
		end
		else if (take_one)
		begin
			unread_one <= 1'b1;
			got_one <= 2'b00;
		end
		else if (!cap1_mode || (unread_one && done_one))
		begin
			unread_one <= 1'b0;
			got_one <= 2'b00;
		end
		else if (rd_hit && idx == IDX_PERCAP_LOW)
		begin
			got_one[0] <= 1'b1;
		end
		else if (rd_hit && idx == IDX_PERCAP_HIGH)
		begin
			got_one[1] <= 1'b1;
		end
	end

	// Capture-two bookkeeping
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			unread_two <= 1'b0;
			got_two <= 2'b00;
		end
		else if (take_two)
		begin
			unread_two <= 1'b1;
			got_two <= 2'b00;
		end
		else if (unread_two && done_two)
		begin
			unread_two <= 1'b0;
			got_two <= 2'b00;
		end
		else if (rd_hit && idx == IDX_CAP2_LOW)
		begin
			got_two[0] <= 1'b1;
		end
		else if (rd_hit && idx == IDX_CAP2_HIGH)
		begin
			got_two[1] <= 1'b1;
		end
	end

	// Shared pair: capture-one holder or Timer3 period, software writes it in period mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			percap <= T3_MAX;
			cap_two <= T3_START;
		end
		else
		begin
			if (take_one)
			begin
				percap <= third_timer_count;
			end
			else if (wr_hit && !cap1_mode && idx == IDX_PERCAP_LOW)
			begin
				percap[7:0] <= wbyte;
			end
			else if (wr_hit && !cap1_mode && idx == IDX_PERCAP_HIGH)
			begin
				percap[15:8] <= wbyte;
			end
			if (take_two)
			begin
				cap_two <= third_timer_count;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and configuration registers
	// ----------------------------------------------------------------
	// Overflow flags clear when written as zero; a new overflow in that cycle wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctl <= CTL_RESET;
			cfg <= CFG_RESET;
			port_b_direction <= DIR_RESET;
			irq_mask <= '0;
		end
		else
		begin
			if (wr_hit && idx == IDX_RUN_CAPTURE_CTL)
			begin
				ctl[5:0] <= wbyte[5:0];
				ctl.cap2_ovf <= ovf_two || (ctl.cap2_ovf && wbyte[7]);
				ctl.cap1_ovf <= ovf_one || (ctl.cap1_ovf && wbyte[6]);
			end
			else
			begin
				ctl.cap2_ovf <= ctl.cap2_ovf || ovf_two;
				ctl.cap1_ovf <= ctl.cap1_ovf || ovf_one;
			end
			if (wr_hit && idx == IDX_CLOCK_EDGE_CFG)
			begin
				cfg <= wbyte;
			end
			if (wr_hit && idx == IDX_PORT_B_DIR)
			begin
				port_b_direction <= wbyte;
			end
			if (wr_hit && idx == IDX_IRQ_MASK)
			begin
				irq_mask <= wbyte[EV_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	logic cascade;
	logic t1_wrap;
	logic t3_wrap;

	assign cascade = cfg[CFG_CASCADE_BIT];
	assign t1_wrap = (timer_one == BYTE_ALL_ONES);
	// Capture mode lets Timer3 run the full 16 bits with no period limit
	assign t3_wrap = cap1_mode ? (third_timer_count == T3_MAX) : (third_timer_count == percap);

	// Timer1 and Timer2; a bus write to a count takes priority over counting
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_one <= '0;
			timer_two <= '0;
		end
		else
		begin
			if (wr_hit && idx == IDX_TIMER_ONE)
			begin
				timer_one <= wbyte;
			end
			else if (ctl.timer_one_run)
			begin
				timer_one <= timer_one + 8'h01;
			end
			if (wr_hit && idx == IDX_TIMER_TWO)
			begin
				timer_two <= wbyte;
			end
			else if (cascade ? (ctl.timer_one_run && ctl.timer_two_run && t1_wrap)
				: ctl.timer_two_run)
			begin
				timer_two <= timer_two + 8'h01;
			end
		end
	end

	// Timer3 counts up and returns to zero at its limit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			third_timer_count <= T3_START;
		end
		else if (wr_hit && idx == IDX_T3_LOW)
		begin
			third_timer_count[7:0] <= wbyte;
		end
		else if (wr_hit && idx == IDX_T3_HIGH)
		begin
			third_timer_count[15:8] <= wbyte;
		end
		else if (ctl.timer_three_run)
		begin
			third_timer_count <= t3_wrap ? T3_START : third_timer_count + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// PWM pins and interrupts
	// ----------------------------------------------------------------
	// Direction bit set means input, so the pin drives while it is clear or while its PWM enable is set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			first_pwm_pin_o <= '0;
			second_pwm_pin_o <= '0;
		end
		else
		begin
			first_pwm_pin_o.out <= ctl.first_pwm_enable ? first_pwm_level_i : first_port_latch_i;
			first_pwm_pin_o.oe <= ctl.first_pwm_enable || !port_b_direction[PB_PWM1_BIT];
			second_pwm_pin_o.out <= ctl.second_pwm_enable ? second_pwm_level_i
				: second_port_latch_i;
			second_pwm_pin_o.oe <= ctl.second_pwm_enable || !port_b_direction[PB_PWM2_BIT];
		end
	end

	logic [EV_W-1:0] events;

	always_comb
	begin
		events = '0;
		events[EV_CAP1] = take_one;
		events[EV_CAP2] = take_two;
		events[EV_OVF1] = ovf_one;
		events[EV_OVF2] = ovf_two;
		events[EV_T3_WRAP] = ctl.timer_three_run && t3_wrap && !(wr_hit && (idx == IDX_T3_LOW
			|| idx == IDX_T3_HIGH));
	end

	// Reading the status clears it, but an event in that same cycle survives
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_status <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_status <= ((rd_hit && idx == IDX_IRQ_STATUS) ? '0 : irq_status) | events;
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Read data, sampled in the wait cycle so it stands at the completing edge
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;

	always_comb
	begin
		rd_byte = 8'h00;
		case (idx)
			IDX_TIMER_ONE: rd_byte = timer_one;
			IDX_TIMER_TWO: rd_byte = timer_two;
			IDX_T3_LOW: rd_byte = third_timer_count[7:0];
			IDX_T3_HIGH: rd_byte = third_timer_count[15:8];
			IDX_CAP2_LOW: rd_byte = cap_two[7:0];
			IDX_CAP2_HIGH: rd_byte = cap_two[15:8];
			IDX_CLOCK_EDGE_CFG: rd_byte = cfg;
			IDX_RUN_CAPTURE_CTL: rd_byte = ctl;
			IDX_PERCAP_LOW: rd_byte = percap[7:0];
			IDX_PERCAP_HIGH: rd_byte = percap[15:8];
			IDX_PORT_B_DIR: rd_byte = port_b_direction;
			IDX_IRQ_STATUS: rd_byte = {3'b000, irq_status};
			IDX_IRQ_MASK: rd_byte = {3'b000, irq_mask};
			default: rd_byte = 8'h00;
		endcase
		if (!aligned)
		begin
			rd_byte = 8'h00;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			avs_readdata <= '0;
		end
		else if (avs_read && avs_waitrequest)
		begin
			avs_readdata <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic t3_written;
	assign t3_written = wr_hit && (idx == IDX_T3_LOW || idx == IDX_T3_HIGH);

	AST_CAP2_OVF: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_two |=> ctl.cap2_ovf)
		else $error("capture two overflow flag not set");
	AST_CAP1_OVF: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_one |=> ctl.cap1_ovf)
		else $error("capture one overflow flag not set");
	AST_CAP2_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(ev_cap2 && unread_two && !done_two) |=> $stable(cap_two) && unread_two)
		else $error("capture two value replaced while unread");
	AST_PWM2_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl.second_pwm_enable |=> second_pwm_pin_o.oe
		&& second_pwm_pin_o.out == $past(second_pwm_level_i))
		else $error("second pwm pin not driven by pwm");
	AST_PWM1_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl.first_pwm_enable |=> first_pwm_pin_o.oe == !$past(port_b_direction[PB_PWM1_BIT]))
		else $error("first pwm pin ignores direction bit");
	AST_T3_FREE: assert property (@(posedge clk_i) disable iff (rst_i)
		(cap1_mode && ctl.timer_three_run && !t3_written && third_timer_count == T3_MAX
		&& third_timer_count != percap) |=> third_timer_count == T3_START)
		else $error("timer three limited in capture mode");
	AST_T3_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctl.timer_three_run && !t3_written) |=> $stable(third_timer_count))
		else $error("timer three moved while stopped");
	AST_T2_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctl.timer_two_run && !(wr_hit && idx == IDX_TIMER_TWO)) |=> $stable(timer_two))
		else $error("timer two moved while its run bit is clear");
	AST_CASCADE_CARRY: assert property (@(posedge clk_i) disable iff (rst_i)
		(cascade && ctl.timer_one_run && ctl.timer_two_run && t1_wrap
		&& !(wr_hit && idx == IDX_TIMER_TWO)) |=> timer_two == $past(timer_two) + 8'h01)
		else $error("cascade carry lost");
	AST_T1_ALONE: assert property (@(posedge clk_i) disable iff (rst_i)
		(!cascade && ctl.timer_one_run && !(wr_hit && idx == IDX_TIMER_ONE))
		|=> timer_one == $past(timer_one) + 8'h01)
		else $error("timer one not counting");
	AST_RUN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_hit && idx == IDX_RUN_CAPTURE_CTL) |=> ctl[5:0] == $past(avs_writedata[5:0]))
		else $error("run bits not applied after write");

endmodule : tcp_timer_control

/* File: verification/testbench.sv */
// Self-checking bench for the timer run and capture control block.
// Assumes the design package is compiled first; one 125 MHz clock.
`timescale 1ns/1ps
module testbench;
	import tcp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic cap_one = 1'b0;
	logic cap_two = 1'b0;
	logic [3:0] lvl = 4'h0;
	tcp_pin_s pin1;
	tcp_pin_s pin2;
	logic irq_o;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int done_cyc = 0;
	integer seed = 32'h24865C16;
	logic [7:0] exp_q[$];
	logic [15:0] per = 16'hFFFF;

	// ----------------------------------------------------------------
	// Design and clock
	// ----------------------------------------------------------------
	tcp_timer_control dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .capture_one_i(cap_one), .capture_two_i(cap_two),
		.first_pwm_level_i(lvl[0]), .second_pwm_level_i(lvl[1]), .first_port_latch_i(lvl[2]),
		.second_port_latch_i(lvl[3]), .first_pwm_pin_o(pin1), .second_pwm_pin_o(pin2),
		.irq_o(irq_o));

	always #4 clk_i = ~clk_i;

	// Cycle count doubles as hang guard; the whole run is far below the ceiling
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			errors++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Read data are taken only at the edge that completes the read
	always @(posedge clk_i)
	begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			check(avs_readdata, {24'h0, exp_q.pop_front()});
	end

	task automatic end_sim();
		$display("TB: errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Avalon-MM master: hold the request until waitrequest is seen low
	// ----------------------------------------------------------------
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
		input logic [3:0] be = 4'hF);
		@(posedge clk_i);
		avs_address <= {idx, 2'b00};
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		do
			@(posedge clk_i);
		while (avs_waitrequest !== 1'b0);
		done_cyc = cyc;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, idx, 8'h00);
	endtask : rd

	// Capture inputs are asynchronous: hold each level long enough for the synchroniser
	task automatic pulse(input bit ch);
		if (ch)
			cap_two <= 1'b1;
		else
			cap_one <= 1'b1;
		repeat (8) @(posedge clk_i);
		cap_one <= 1'b0;
		cap_two <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : pulse

	// Run the timers for a random span and compare with a cycle model
	task automatic run_timers(input logic [7:0] ctl, input logic casc);
		logic [7:0] t1;
		logic [7:0] t2;
		logic [15:0] t3;
		int k;
		t1 = 8'hFE;
		t2 = 8'h10;
		t3 = 16'h01FE;
		bus(1'b1, IDX_CLOCK_EDGE_CFG, {4'h0, casc, 3'h0});
		bus(1'b1, IDX_TIMER_ONE, t1);
		bus(1'b1, IDX_TIMER_TWO, t2);
		bus(1'b1, IDX_T3_LOW, t3[7:0]);
		bus(1'b1, IDX_T3_HIGH, t3[15:8]);
		bus(1'b1, IDX_RUN_CAPTURE_CTL, ctl);
		k = done_cyc;
		repeat (($random(seed) & 7) + 2) @(posedge clk_i);
		bus(1'b1, IDX_RUN_CAPTURE_CTL, 8'h00);
		k = done_cyc - k;
		repeat (k)
		begin
			if (casc && ctl[0] && ctl[1] && t1 == 8'hFF)
				t2++;
			if (ctl[0])
				t1++;
			if (!casc && ctl[1])
				t2++;
			if (ctl[2])
				t3 = (!ctl[3] && t3 == per) ? 16'h0000 : t3 + 16'h0001;
		end
		rd(IDX_TIMER_ONE, t1);
		rd(IDX_TIMER_TWO, t2);
		rd(IDX_T3_LOW, t3[7:0]);
		rd(IDX_T3_HIGH, t3[15:8]);
	endtask : run_timers

	// Capture, overflow, retention and the interrupt path for one channel
	task automatic cap_test(input bit ch);
		logic [7:0] base;
		logic [7:0] ovf;
		logic [7:0] st;
		logic [5:0] lo;
		base = ch ? 8'h00 : 8'h08;
		ovf = ch ? 8'h80 : 8'h40;
		st = ch ? 8'h0A : 8'h05;
		lo = ch ? IDX_CAP2_LOW : IDX_PERCAP_LOW;
		bus(1'b1, IDX_RUN_CAPTURE_CTL, base);
		bus(1'b1, IDX_T3_LOW, 8'h34);
		bus(1'b1, IDX_T3_HIGH, 8'h12);
		pulse(ch);
		bus(1'b1, IDX_T3_LOW, 8'h78);
		bus(1'b1, IDX_T3_HIGH, 8'h56);
		pulse(ch);
		rd(IDX_RUN_CAPTURE_CTL, base | ovf);
		check(irq_o, 1'b0);
		rd(lo, 8'h34);
		rd(lo + 6'h01, 8'h12);
		pulse(ch);
		rd(lo, 8'h78);
		rd(lo + 6'h01, 8'h56);
		bus(1'b1, IDX_IRQ_MASK, st);
		repeat (2) @(posedge clk_i);
		check(irq_o, 1'b1);
		rd(IDX_IRQ_STATUS, st);
		repeat (2) @(posedge clk_i);
		check(irq_o, 1'b0);
		bus(1'b1, IDX_RUN_CAPTURE_CTL, 8'h00);
		rd(IDX_RUN_CAPTURE_CTL, 8'h00);
	endtask : cap_test

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic en;
		logic dir;
		logic sel;
		tcp_pin_s pa;
		tcp_pin_s pb;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({pin1.oe, pin2.oe, irq_o}, 3'b000);
		rd(IDX_RUN_CAPTURE_CTL, CTL_RESET);
		rd(IDX_PORT_B_DIR, DIR_RESET);
		rd(IDX_PERCAP_HIGH, 8'hFF);
		rd(IDX_CAP2_LOW, 8'h00);
		rd(6'h3F, 8'h00);
		bus(1'b1, IDX_RUN_CAPTURE_CTL, 8'h04, 4'h0);
		rd(IDX_RUN_CAPTURE_CTL, 8'h00);
		bus(1'b1, IDX_PERCAP_LOW, 8'h5A);
		rd(IDX_PERCAP_LOW, 8'h5A);
		per = {T3_MAX[15:8], 8'h5A};
		rd(IDX_IRQ_STATUS, 8'h00);
		$display("TB: test reset done");
		run_timers(8'h07, 1'b0);
		run_timers(8'h03, 1'b1);
		run_timers(8'h01, 1'b1);
		run_timers(8'h02, 1'b0);
		// A short period makes Timer3 wrap in period mode but not in capture mode
		bus(1'b1, IDX_PERCAP_LOW, 8'h01);
		bus(1'b1, IDX_PERCAP_HIGH, 8'h02);
		per = 16'h0201;
		run_timers(8'h04, 1'b0);
		rd(IDX_IRQ_STATUS, 8'h10);
		run_timers(8'h0C, 1'b0);
		rd(IDX_IRQ_STATUS, 8'h00);
		$display("TB: test timers done");
		for (int i = 0; i < 8; i++)
		begin
			{sel, dir, en} = i[2:0];
			lvl <= 4'($random(seed));
			bus(1'b1, IDX_PORT_B_DIR, dir ? 8'hFF : 8'hF3);
			bus(1'b1, IDX_RUN_CAPTURE_CTL, en ? (sel ? 8'h20 : 8'h10) : 8'h00);
			repeat (3) @(posedge clk_i);
			pa = sel ? pin2 : pin1;
			pb = sel ? pin1 : pin2;
			check(pa.oe, en | !dir);
			check(pb.oe, !dir);
			if (en | !dir)
				check(pa.out, en ? lvl[sel] : lvl[2 + sel]);
		end
		bus(1'b1, IDX_RUN_CAPTURE_CTL, 8'h00);
		$display("TB: test pwm pins done");
		cap_test(1'b0);
		cap_test(1'b1);
		$display("TB: test capture done");
		repeat (4) @(posedge clk_i);
		end_sim();
	end
endmodule : testbench
